/* File: tam_pkg.sv */
/*
  Shared constants for the temperature supervision and converter readout
  block: timing figures, derived cycle counts, status fields, converter
  channel codes and reset values.
  Assumes the system clock rate given below.
*/
package tam_pkg;

  // System clock
  localparam int  SYS_CLK_HZ        = 20_000_000;

  // Timing figures in their own units
  localparam real OT_FILT_TIME_MS   = 2.0;
  localparam real DIE_FILT_TIME_US  = 20.0;
  localparam real IDLE_TIME_US      = 200.0;
  localparam real ANALOG_DUTY_OUTPUT_FREQ_A_HZ    = 3900.0;
  localparam real ANALOG_DUTY_OUTPUT_FREQ_B_HZ    = 5600.0;

  // Derived cycle counts; filters are least times, rounded up
  localparam int  OT_FILT_CYC   = int'($ceil(OT_FILT_TIME_MS * SYS_CLK_HZ / 1.0e3));
  localparam int  DIE_FILT_CYC  = int'($ceil(DIE_FILT_TIME_US * SYS_CLK_HZ / 1.0e6));
  localparam int  IDLE_CYC      = int'($ceil(IDLE_TIME_US * SYS_CLK_HZ / 1.0e6));
  localparam int  ANALOG_DUTY_OUTPUT_PER_A_CYC = int'($floor(SYS_CLK_HZ / ANALOG_DUTY_OUTPUT_FREQ_A_HZ));
  localparam int  ANALOG_DUTY_OUTPUT_PER_B_CYC = int'($floor(SYS_CLK_HZ / ANALOG_DUTY_OUTPUT_FREQ_B_HZ));

  // Converter data
  localparam int          CONV_W   = 10;
  localparam int          IDLE_W   = 12;
  localparam logic [9:0]  RST_CONV = 10'h000;

  // Fault status field positions
  localparam int  FS_W     = 4;
  localparam int  FS_OTW   = 0;
  localparam int  FS_OVERTEMP_SHUTDOWN  = 1;
  localparam int  FS_DIE   = 2;
  localparam int  FS_GMF   = 3;

  // On-die sensor index
  localparam int  DIE_N    = 3;
  localparam int  DIE_LV   = 0;
  localparam int  DIE_GH   = 1;
  localparam int  DIE_GL   = 2;

  // Analog select codes
  localparam logic [2:0] SEL_EXT_TEMP = 3'h0;
  localparam logic [2:0] SEL_AUX      = 3'h1;
  localparam logic [2:0] SEL_VCC      = 3'h2;
  localparam logic [2:0] SEL_REGULATED_GATE_SUPPLY   = 3'h3;
  localparam logic [2:0] SEL_VEE      = 3'h4;
  localparam logic [2:0] SEL_DIE_GH   = 3'h5;

  typedef enum logic {TAM_SY_IDLE, TAM_SY_WAIT} tam_sys_e;
  typedef enum logic {TAM_LK_IDLE, TAM_LK_BUSY} tam_link_e;

endpackage

/* File: tam_persist_filter.sv */
/*
  Persistence filter: output rises once the input has stayed high for CYC
  consecutive clocks and falls on the first clock it is seen low.
  Assumes the input is already synchronous to clk_sys_i.
*/
`timescale 1ns/1ns
`default_nettype none
module tam_persist_filter #(
  parameter int CYC = 400
) (
  // Clock and reset
  input  wire logic clk_sys_i,
  input  wire logic sys_rst_i,
  // Condition
  input  wire logic raw_i,
  output logic      filt_o
);
  localparam int W = (CYC > 1) ? $clog2(CYC) : 1;

  logic [W-1:0] cnt_ff;

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cnt_ff <= '0;
      filt_o <= 1'b0;
    end else if (!raw_i) begin
      cnt_ff <= '0;
      filt_o <= 1'b0;
    end else if (cnt_ff == W'(CYC - 1)) begin
      filt_o <= 1'b1;
    end else begin
      cnt_ff <= cnt_ff + 1'b1;
    end
  end

endmodule
`default_nettype wire

/* File: tam_monitor.sv */
/*
  Temperature supervision and converter readout: external sensor thresholds
  with filtering and fault latching, on-die overtemperature shutdown, gate
  reaction, converter request crossing to the link clock, duty-coded output.
  Assumes config and strobes come from register logic on clk_sys_i and the
  converter answers on clk_link_i.
*/
`timescale 1ns/1ns
`default_nettype none
// Functional notes
// - Sense current enable follows its control bit
// - Thresholds changeable live, used next comparison
// - Warning above shutdown: trip below shutdown threshold
// - Warning below shutdown: trip above shutdown threshold
// - Shutdown and warning filtered for 2.0 ms
// - Warning latched, reported, gate untouched
// - Shutdown latched, reported, normal gate turn-off
// - Warning present hides gate monitor fault fully
// - 200 us idle starts automatic conversion
// - Hold 10-bit temperature for readout and output
// - Any die sensor trips die overtemperature
// - Die overtemperature: high off, low on, clamp
// - High- or low-side gate die fault also drops gate supplies
// - Die detectors filtered for 20 us
// - Only high-side die sensor is selectable
// - Convert source chosen by 3-bit select
// - Codes span 000h to 3FFh full scale
// - Negative supply: 000h at -15 V
// - Converter request restarts idle timer
// - Output alternates temperature and secondary frames
// - Faults clear on write-one when gone
// - Output keeps last valid converter value
module tam_monitor
  import tam_pkg::*;
#(
  parameter int OT_FILT_CYCLES = OT_FILT_CYC,
  parameter int ANALOG_DUTY_OUTPUT_PER_A     = ANALOG_DUTY_OUTPUT_PER_A_CYC,
  parameter int ANALOG_DUTY_OUTPUT_PER_B     = ANALOG_DUTY_OUTPUT_PER_B_CYC
) (
  // System clock and reset
  input  wire logic              clk_sys_i,
  input  wire logic              sys_rst_i,
  // Configuration
  input  wire logic              temp_sense_current_enable_i,
  input  wire logic [CONV_W-1:0] overtemp_threshold_i,
  input  wire logic [CONV_W-1:0] overtemp_warning_threshold_i,
  input  wire logic              dual_output_enable_i,
  input  wire logic [2:0]        secondary_output_select_i,
  input  wire logic              miller_clamp_enable_i,
  input  wire logic [FS_W-1:0]   fault_clear_i,
  // Gate command and gate monitor
  input  wire logic              pwm_i,
  input  wire logic              gate_monitor_fault_i,
  // Serial side converter requests
  input  wire logic              spi_activity_i,
  input  wire logic              adc_request_i,
  input  wire logic [2:0]        analog_select_i,
  output logic                   adc_busy_o,
  output logic                   conversion_valid_o,
  output logic [CONV_W-1:0]      conversion_result_o,
  output logic [CONV_W-1:0]      ext_temp_value_o,
  // On-die sensor pins
  input  wire logic [DIE_N-1:0]  die_hot_i,
  // Status and reactions
  output logic [FS_W-1:0]        fault_status_a_o,
  output logic                   die_overtemp_flag_o,
  output logic                   fault_interrupt_out_n_o,
  output logic                   temp_sense_current_enable_o,
  output logic                   gate_high_driver_o,
  output logic                   gate_low_driver_o,
  output logic                   miller_clamp_o,
  output logic                   regulated_gate_supply_en_o,
  output logic                   reference_regulator_en_o,
  output logic                   analog_duty_output_o,
  // Converter link
  input  wire logic              clk_link_i,
  input  wire logic              adc_done_i,
  input  wire logic [CONV_W-1:0] adc_data_i,
  output logic                   adc_start_o,
  output logic [2:0]             adc_channel_o
);
  localparam int ANALOG_DUTY_OUTPUT_CW = $clog2(ANALOG_DUTY_OUTPUT_PER_A + 1);

  tam_sys_e          st_ff;
  tam_link_e         lst_ff;
  logic [IDLE_W-1:0] idle_cnt_ff;
  logic              req_tgl_ff;
  logic [2:0]        chan_hold_ff;
  logic              auto_sec_ff;
  logic              ack_s1_ff, ack_s2_ff, ack_s3_ff;
  logic              lrst_s1_ff, lrst_ff;
  logic              lreq_s1_ff, lreq_s2_ff, lreq_s3_ff;
  logic              ack_tgl_ff;
  logic [CONV_W-1:0] ldata_ff;
  logic [CONV_W-1:0] sec_val_ff;
  logic              new_temp_ff;
  logic              cond_ot_ff, cond_otw_ff;
  logic              filt_ot, filt_otw;
  logic [DIE_N-1:0]  die_s1_ff, die_s2_ff, die_filt;
  logic              otw_ff, overtemp_shutdown_ff, die_ff, die_hv_ff, gmf_ff;
  logic              gmf_vis, gate_off;
  logic [ANALOG_DUTY_OUTPUT_CW-1:0] analog_duty_output_cnt_ff, duty_ff;
  logic              frame_b_ff;
  logic              issue, auto_issue, ack_edge, ntc;
  logic [2:0]        issue_chan;
  logic [CONV_W-1:0] frame_val;
  logic [ANALOG_DUTY_OUTPUT_CW-1:0] frame_per;
  logic [ANALOG_DUTY_OUTPUT_CW+CONV_W-1:0] duty_prod;

  // Request arbitration; serial requests win over the idle refresh
  assign auto_issue = (st_ff == TAM_SY_IDLE) && !adc_request_i
                      && (idle_cnt_ff == IDLE_W'(IDLE_CYC - 1));
  assign issue      = ((st_ff == TAM_SY_IDLE) && adc_request_i) || auto_issue;
  assign issue_chan = adc_request_i ? analog_select_i
                    : ((dual_output_enable_i && auto_sec_ff)
                       ? secondary_output_select_i : SEL_EXT_TEMP);
  assign adc_busy_o = (st_ff == TAM_SY_WAIT);
  assign ack_edge   = ack_s2_ff ^ ack_s3_ff;

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      idle_cnt_ff <= '0;
    end else if (spi_activity_i || adc_request_i || issue) begin
      idle_cnt_ff <= '0;
    end else if (idle_cnt_ff != IDLE_W'(IDLE_CYC - 1)) begin
      idle_cnt_ff <= idle_cnt_ff + 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st_ff        <= TAM_SY_IDLE;
      req_tgl_ff   <= 1'b0;
      chan_hold_ff <= SEL_EXT_TEMP;
      auto_sec_ff  <= 1'b0;
    end else begin
      case (st_ff)
        TAM_SY_IDLE: begin
          if (issue) begin
            chan_hold_ff <= issue_chan;
            req_tgl_ff   <= ~req_tgl_ff;
            st_ff        <= TAM_SY_WAIT;
            if (auto_issue) begin
              auto_sec_ff <= dual_output_enable_i && !auto_sec_ff;
            end
          end
        end
        TAM_SY_WAIT: begin
          if (ack_edge) begin
            st_ff <= TAM_SY_IDLE;
          end
        end
        default: st_ff <= TAM_SY_IDLE;
      endcase
    end
  end

  // Result side: the link holds its data word until the next request
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ack_s1_ff <= 1'b0;
      ack_s2_ff <= 1'b0;
      ack_s3_ff <= 1'b0;
    end else begin
      ack_s1_ff <= ack_tgl_ff;
      ack_s2_ff <= ack_s1_ff;
      ack_s3_ff <= ack_s2_ff;
    end
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      conversion_valid_o  <= 1'b0;
      conversion_result_o <= RST_CONV;
      ext_temp_value_o    <= RST_CONV;
      sec_val_ff          <= RST_CONV;
      new_temp_ff         <= 1'b0;
    end else begin
      conversion_valid_o <= 1'b0;
      new_temp_ff        <= 1'b0;
      if ((st_ff == TAM_SY_WAIT) && ack_edge) begin
        conversion_valid_o  <= 1'b1;
        conversion_result_o <= ldata_ff;
        if (chan_hold_ff == SEL_EXT_TEMP) begin
          ext_temp_value_o <= ldata_ff;
          new_temp_ff      <= 1'b1;
        end
        if (chan_hold_ff == secondary_output_select_i) begin
          sec_val_ff <= ldata_ff;
        end
      end
    end
  end

  // Link domain: reset released on its own clock
  always_ff @(posedge clk_link_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      lrst_s1_ff <= 1'b1;
      lrst_ff    <= 1'b1;
    end else begin
      lrst_s1_ff <= 1'b0;
      lrst_ff    <= lrst_s1_ff;
    end
  end

  always_ff @(posedge clk_link_i or posedge lrst_ff) begin
    if (lrst_ff) begin
      lreq_s1_ff <= 1'b0;
      lreq_s2_ff <= 1'b0;
      lreq_s3_ff <= 1'b0;
    end else begin
      lreq_s1_ff <= req_tgl_ff;
      lreq_s2_ff <= lreq_s1_ff;
      lreq_s3_ff <= lreq_s2_ff;
    end
  end

  // Channel word is stable while the request toggle is in flight
  always_ff @(posedge clk_link_i or posedge lrst_ff) begin
    if (lrst_ff) begin
      lst_ff        <= TAM_LK_IDLE;
      adc_start_o   <= 1'b0;
      adc_channel_o <= SEL_EXT_TEMP;
      ldata_ff      <= RST_CONV;
      ack_tgl_ff    <= 1'b0;
    end else begin
      adc_start_o <= 1'b0;
      case (lst_ff)
        TAM_LK_IDLE: begin
          if (lreq_s2_ff ^ lreq_s3_ff) begin
            adc_start_o   <= 1'b1;
            adc_channel_o <= chan_hold_ff;
            lst_ff        <= TAM_LK_BUSY;
          end
        end
        TAM_LK_BUSY: begin
          if (adc_done_i) begin
            ldata_ff   <= adc_data_i;
            ack_tgl_ff <= ~ack_tgl_ff;
            lst_ff     <= TAM_LK_IDLE;
          end
        end
        default: lst_ff <= TAM_LK_IDLE;
      endcase
    end
  end

  // Threshold comparison on each fresh temperature result
  assign ntc = overtemp_warning_threshold_i > overtemp_threshold_i;

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cond_ot_ff  <= 1'b0;
      cond_otw_ff <= 1'b0;
    end else if (new_temp_ff) begin
      if (ntc) begin
        cond_ot_ff  <= ext_temp_value_o < overtemp_threshold_i;
        cond_otw_ff <= ext_temp_value_o < overtemp_warning_threshold_i;
      end else begin
        cond_ot_ff  <= ext_temp_value_o > overtemp_threshold_i;
        cond_otw_ff <= ext_temp_value_o > overtemp_warning_threshold_i;
      end
    end
  end

  tam_persist_filter #(.CYC(OT_FILT_CYCLES)) u_filt_ot (
    .clk_sys_i (clk_sys_i),
    .sys_rst_i (sys_rst_i),
    .raw_i     (cond_ot_ff),
    .filt_o    (filt_ot)
  );

  tam_persist_filter #(.CYC(OT_FILT_CYCLES)) u_filt_otw (
    .clk_sys_i (clk_sys_i),
    .sys_rst_i (sys_rst_i),
    .raw_i     (cond_otw_ff),
    .filt_o    (filt_otw)
  );

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      die_s1_ff <= '0;
      die_s2_ff <= '0;
    end else begin
      die_s1_ff <= die_hot_i;
      die_s2_ff <= die_s1_ff;
    end
  end

  for (genvar g = 0; g < DIE_N; g++) begin : g_die
    tam_persist_filter #(.CYC(DIE_FILT_CYC)) u_filt_die (
      .clk_sys_i (clk_sys_i),
      .sys_rst_i (sys_rst_i),
      .raw_i     (die_s2_ff[g]),
      .filt_o    (die_filt[g])
    );
  end

  // Fault latches: a new event wins over a clear in the same cycle
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      otw_ff    <= 1'b0;
      overtemp_shutdown_ff   <= 1'b0;
      die_ff    <= 1'b0;
      die_hv_ff <= 1'b0;
      gmf_ff    <= 1'b0;
    end else begin
      if (filt_otw) begin
        otw_ff <= 1'b1;
      end else if (fault_clear_i[FS_OTW]) begin
        otw_ff <= 1'b0;
      end
      if (filt_ot) begin
        overtemp_shutdown_ff <= 1'b1;
      end else if (fault_clear_i[FS_OVERTEMP_SHUTDOWN]) begin
        overtemp_shutdown_ff <= 1'b0;
      end
      if (|die_filt) begin
        die_ff <= 1'b1;
      end else if (fault_clear_i[FS_DIE]) begin
        die_ff <= 1'b0;
      end
      if (die_filt[DIE_GH] || die_filt[DIE_GL]) begin
        die_hv_ff <= 1'b1;
      end else if (fault_clear_i[FS_DIE]) begin
        die_hv_ff <= 1'b0;
      end
      if (gate_monitor_fault_i && !otw_ff) begin
        gmf_ff <= 1'b1;
      end else if (fault_clear_i[FS_GMF]) begin
        gmf_ff <= 1'b0;
      end
    end
  end

  assign gmf_vis  = gmf_ff && !otw_ff;
  assign gate_off = overtemp_shutdown_ff || die_ff || gmf_vis;

  // Reactions and reporting, all registered
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      fault_status_a_o            <= '0;
      die_overtemp_flag_o         <= 1'b0;
      fault_interrupt_out_n_o     <= 1'b1;
      temp_sense_current_enable_o <= 1'b0;
      gate_high_driver_o          <= 1'b0;
      gate_low_driver_o           <= 1'b1;
      miller_clamp_o              <= 1'b0;
      regulated_gate_supply_en_o  <= 1'b1;
      reference_regulator_en_o    <= 1'b1;
    end else begin
      fault_status_a_o            <= {gmf_vis, die_ff, overtemp_shutdown_ff, otw_ff};
      die_overtemp_flag_o         <= die_ff;
      fault_interrupt_out_n_o     <= !(otw_ff || overtemp_shutdown_ff || die_ff || gmf_vis);
      temp_sense_current_enable_o <= temp_sense_current_enable_i;
      gate_high_driver_o          <= pwm_i && !gate_off;
      gate_low_driver_o           <= !pwm_i || gate_off;
      miller_clamp_o              <= miller_clamp_enable_i && (!pwm_i || gate_off);
      regulated_gate_supply_en_o  <= !die_hv_ff;
      reference_regulator_en_o    <= !die_hv_ff;
    end
  end

  // Duty-coded output; frame values are the last results held
  assign frame_val = frame_b_ff ? sec_val_ff : ext_temp_value_o;
  assign frame_per = frame_b_ff ? ANALOG_DUTY_OUTPUT_CW'(ANALOG_DUTY_OUTPUT_PER_B) : ANALOG_DUTY_OUTPUT_CW'(ANALOG_DUTY_OUTPUT_PER_A);
  assign duty_prod = frame_val * frame_per;

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      analog_duty_output_cnt_ff          <= '0;
      duty_ff              <= '0;
      frame_b_ff           <= 1'b0;
      analog_duty_output_o <= 1'b0;
    end else begin
      // First cycle of a frame must use the new frame's value, not the old
      if (analog_duty_output_cnt_ff == '0) begin
        analog_duty_output_o <= duty_prod[ANALOG_DUTY_OUTPUT_CW+CONV_W-1:CONV_W] != '0;
      end else begin
        analog_duty_output_o <= analog_duty_output_cnt_ff < duty_ff;
      end
      if (analog_duty_output_cnt_ff == frame_per - 1'b1) begin
        analog_duty_output_cnt_ff <= '0;
        frame_b_ff  <= dual_output_enable_i && !frame_b_ff;
      end else begin
        analog_duty_output_cnt_ff <= analog_duty_output_cnt_ff + 1'b1;
        if (analog_duty_output_cnt_ff == '0) begin
          duty_ff <= duty_prod[ANALOG_DUTY_OUTPUT_CW+CONV_W-1:CONV_W];
        end
      end
    end
  end

  // Checks
  int ot_run_cnt;

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ot_run_cnt <= 0;
    end else begin
      ot_run_cnt <= cond_ot_ff ? ot_run_cnt + 1 : 0;
    end
  end

  property p_ot_filter;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    $rose(filt_ot) |-> $past(cond_ot_ff) && ($past(ot_run_cnt) >= OT_FILT_CYCLES - 1);
  endproperty
  a_ot_filter: assert property (p_ot_filter) else $error("shutdown filter too short");

  property p_otw_report;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    otw_ff |=> !fault_interrupt_out_n_o && fault_status_a_o[FS_OTW];
  endproperty
  a_otw_report: assert property (p_otw_report) else $error("warning not reported");

  property p_overtemp_shutdown_gate;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    overtemp_shutdown_ff |=> !gate_high_driver_o && gate_low_driver_o;
  endproperty
  a_overtemp_shutdown_gate: assert property (p_overtemp_shutdown_gate) else $error("gate on during shutdown");

  property p_gmf_masked;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    otw_ff |=> !fault_status_a_o[FS_GMF];
  endproperty
  a_gmf_masked: assert property (p_gmf_masked) else $error("gate monitor fault not hidden");

  property p_auto_request;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    (st_ff == TAM_SY_IDLE && !adc_request_i && idle_cnt_ff == IDLE_W'(IDLE_CYC - 1))
      |=> $changed(req_tgl_ff) && (st_ff == TAM_SY_WAIT);
  endproperty
  a_auto_request: assert property (p_auto_request) else $error("idle refresh missing");

  property p_die_gate;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    $rose(die_ff) |=> die_overtemp_flag_o && !gate_high_driver_o ##0 gate_low_driver_o;
  endproperty
  a_die_gate: assert property (p_die_gate) else $error("die fault without gate off");

  property p_hv_supply;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    die_hv_ff |=> !regulated_gate_supply_en_o && !reference_regulator_en_o;
  endproperty
  a_hv_supply: assert property (p_hv_supply) else $error("supply still on");

  property p_die_filter;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    $rose(die_filt[DIE_GH]) |-> $past(die_s2_ff[DIE_GH], 8);
  endproperty
  a_die_filter: assert property (p_die_filter) else $error("die filter too short");

  property p_sticky;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    (overtemp_shutdown_ff && filt_ot) |=> overtemp_shutdown_ff;
  endproperty
  a_sticky: assert property (p_sticky) else $error("fault cleared while present");

  property p_ntc_compare;
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    (new_temp_ff && ntc && ext_temp_value_o < overtemp_threshold_i) |=> cond_ot_ff;
  endproperty
  a_ntc_compare: assert property (p_ntc_compare) else $error("compare direction wrong");

  c_overtemp_shutdown:   cover property (@(posedge clk_sys_i) disable iff (sys_rst_i) $rose(overtemp_shutdown_ff));
  c_die:    cover property (@(posedge clk_sys_i) disable iff (sys_rst_i) $rose(die_hv_ff));
  c_result: cover property (@(posedge clk_sys_i) disable iff (sys_rst_i)
                            conversion_valid_o && dual_output_enable_i);
  c_analog_duty_output:   cover property (@(posedge clk_sys_i) disable iff (sys_rst_i)
                            $rose(analog_duty_output_o) && frame_b_ff);

endmodule
`default_nettype wire

/* File: tam_adc_model.sv */
/*
  Converter model on the link clock: answers each start with one done.
  Assumes the bench sets value_i before the start pulse arrives.
*/
`timescale 1ns/1ns
`default_nettype none
module tam_adc_model #(
  parameter int LAT = 2
) (
  input  wire logic       clk_link_i,
  input  wire logic       adc_start_i,
  input  wire logic [9:0] value_i,
  output logic            adc_done_o,
  output logic [9:0]      adc_data_o
);
  int cnt = 0;
  initial begin
    adc_done_o = 1'b0;
    adc_data_o = 10'h3FF;
  end
  always @(posedge clk_link_i) begin
    adc_done_o <= 1'b0;
    // Stale data flips so a late sample cannot pass
    adc_data_o <= ~adc_data_o;
    if (adc_start_i) cnt <= LAT;
    else if (cnt != 0) cnt <= cnt - 1;
    if (cnt == 1) begin
      adc_done_o <= 1'b1;
      adc_data_o <= value_i;
    end
  end
endmodule
`default_nettype wire

/* File: tam_monitor_test.sv */
/*
  Bench for the temperature monitor: conversions, faults, die shutdown.
  Assumes the converter model on the link clock.
*/
`timescale 1ns/1ns
`default_nettype none
module tam_monitor_test;
  import tam_pkg::*;
  logic clk_sys_i = 0, clk_link_i = 0, sys_rst_i = 1, tsc = 0, req = 0, gmf = 0;
  logic pwm = 1, mce = 1, dual = 0, spi = 0, rref, ad;
  logic [9:0] ot = 10'h0C8, overtemp_warning = 10'h064, mval = 0, res, ext, ddat;
  logic [3:0] clr = 0, fs;
  logic [2:0] sel = 0, die = 0, ch;
  logic busy, vld, dflag, intn, gh, gl, miller_clamp, sup, tsc_o, start, done;
  int bad_count = 0, n_compared = 0, cyc = 0, n;
  wire logic [9:0] st = {fs, dflag, intn, gh, gl, miller_clamp, sup};
  always #25 clk_sys_i = ~clk_sys_i;
  always begin
    #61 clk_link_i = ~clk_link_i;
    #64 clk_link_i = ~clk_link_i;
  end
  tam_monitor #(.OT_FILT_CYCLES(50), .ANALOG_DUTY_OUTPUT_PER_A(64), .ANALOG_DUTY_OUTPUT_PER_B(48)) dut (
    .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .temp_sense_current_enable_i(tsc),
    .overtemp_threshold_i(ot), .overtemp_warning_threshold_i(overtemp_warning),
    .dual_output_enable_i(dual), .secondary_output_select_i(3'h0),
    .miller_clamp_enable_i(mce), .fault_clear_i(clr), .pwm_i(pwm),
    .gate_monitor_fault_i(gmf), .spi_activity_i(spi), .adc_request_i(req),
    .analog_select_i(sel), .adc_busy_o(busy), .conversion_valid_o(vld),
    .conversion_result_o(res), .ext_temp_value_o(ext), .die_hot_i(die),
    .fault_status_a_o(fs), .die_overtemp_flag_o(dflag), .fault_interrupt_out_n_o(intn),
    .temp_sense_current_enable_o(tsc_o), .gate_high_driver_o(gh), .gate_low_driver_o(gl),
    .miller_clamp_o(miller_clamp), .regulated_gate_supply_en_o(sup), .reference_regulator_en_o(rref),
    .analog_duty_output_o(ad), .clk_link_i(clk_link_i), .adc_done_i(done),
    .adc_data_i(ddat), .adc_start_o(start), .adc_channel_o(ch));
  tam_adc_model model (.clk_link_i(clk_link_i), .adc_start_i(start), .value_i(mval),
    .adc_done_o(done), .adc_data_o(ddat));
  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc_wait(input int k);
    repeat (k) @(negedge clk_sys_i);
  endtask
  task automatic wait_valid();
    n = 0;
    while (vld !== 1'b1 && n < 5000) begin
      @(negedge clk_sys_i);
      n++;
    end
  endtask
  task automatic convert(input logic [2:0] c, input logic [9:0] v);
    mval <= v;
    while (busy !== 1'b0) @(negedge clk_sys_i);
    @(posedge clk_sys_i);
    req <= 1'b1;
    sel <= c;
    @(posedge clk_sys_i);
    req <= 1'b0;
    wait_valid();
    chk(res, v);
    chk({7'h00, ch}, {7'h00, c});
  endtask
  task automatic clear(input logic [3:0] m);
    // Let the filtered condition drop first; a new event beats a clear
    cyc_wait(3);
    @(posedge clk_sys_i);
    clr <= m;
    @(posedge clk_sys_i);
    clr <= 4'h0;
    cyc_wait(4);
  endtask
  task automatic high_count(input int k);
    n = 0;
    repeat (k) begin
      @(negedge clk_sys_i);
      if (ad === 1'b1) n++;
    end
  endtask
  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Ceiling well above the roughly 6600 cycles the sequence needs
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      end_of_test();
    end
  end
  initial begin
    repeat (16) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    tsc <= 1'b1;
    cyc_wait(4);
    chk(st, 10'h019);
    chk({9'h000, tsc_o}, 10'h001);
    @(posedge clk_sys_i);
    tsc <= 1'b0;
    pwm <= 1'b0;
    cyc_wait(3);
    chk({9'h000, tsc_o}, 10'h000);
    chk(st, 10'h017);
    @(posedge clk_sys_i);
    mce <= 1'b0;
    cyc_wait(3);
    chk(st, 10'h015);
    @(posedge clk_sys_i);
    pwm <= 1'b1;
    mce <= 1'b1;
    for (int c = 0; c < 6; c++) convert(3'(c), 10'h040 + 10'(c));
    chk(ext, 10'h040);
    convert(SEL_DIE_GH, 10'h18C);
    chk(10'(int'(372.0 - res / 1.982)), 10'h0AC);
    convert(3'h0, 10'h096);
    cyc_wait(40);
    chk(st, 10'h019);
    cyc_wait(20);
    chk(st, 10'h049);
    @(posedge clk_sys_i);
    gmf <= 1'b1;
    @(posedge clk_sys_i);
    gmf <= 1'b0;
    cyc_wait(4);
    chk(st, 10'h049);
    clear(4'hF);
    chk(st, 10'h049);
    convert(3'h0, 10'h032);
    clear(4'h1);
    chk(st, 10'h019);
    @(posedge clk_sys_i);
    gmf <= 1'b1;
    @(posedge clk_sys_i);
    gmf <= 1'b0;
    cyc_wait(4);
    chk(st, 10'h207);
    clear(4'h8);
    chk(st, 10'h019);
    convert(3'h0, 10'h12C);
    cyc_wait(60);
    chk(st, 10'h0C7);
    convert(3'h0, 10'h032);
    clear(4'h3);
    @(posedge clk_sys_i);
    ot <= 10'h258;
    overtemp_warning <= 10'h320;
    convert(3'h0, 10'h1F4);
    cyc_wait(60);
    chk(st, 10'h0C7);
    convert(3'h0, 10'h2BC);
    clear(4'h3);
    chk(st, 10'h049);
    convert(3'h0, 10'h384);
    clear(4'h1);
    for (int i = 0; i < 3; i++) begin
      @(posedge clk_sys_i);
      die <= 3'(1 << i);
      cyc_wait(380);
      chk(st, 10'h019);
      cyc_wait(40);
      chk(st, 10'h126 | 10'(i == 0));
      chk(10'(rref), 10'(i == 0));
      @(posedge clk_sys_i);
      die <= 3'h0;
      cyc_wait(5);
      clear(4'h4);
      chk(st, 10'h019);
    end
    @(posedge clk_sys_i);
    spi <= 1'b1;
    mval <= 10'h155;
    @(posedge clk_sys_i);
    spi <= 1'b0;
    wait_valid();
    chk(10'(n > 4000 && n < 4100), 10'h001);
    chk(res, 10'h155);
    chk(ext, 10'h155);
    cyc_wait(140);
    high_count(64);
    chk(10'(n), 10'h015);
    @(posedge clk_sys_i);
    dual <= 1'b1;
    cyc_wait(300);
    high_count(112);
    chk(10'(n), 10'h024);
    end_of_test();
  end
endmodule
`default_nettype wire
